// >>> pfer_recorder.sv
// PMBus fault alert and black-box event recorder, core plus byte-level link
`include "pfer_regs.svh"
`timescale 1ns/100ps
`default_nettype none
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
module pfer_recorder #(
  parameter int unsigned TICK_CYCLES = `PFER_TICK_MS * `PFER_CLK_MHZ * 1000,
  parameter int unsigned WIPE_CYCLES = `PFER_WIPE_MS * `PFER_CLK_MHZ * 1000,
  parameter logic [31:0] IDLE_TICKS = `PFER_IDLE_TICKS,
  parameter int unsigned SLOTS = `PFER_BANK_SLOTS
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic LINK_CLK,
  input wire logic LINK_CMD_VALID,
  input wire logic [7:0] LINK_CMD,
  input wire logic LINK_WR,
  input wire logic [7:0] LINK_WDATA,
  input wire logic LINK_BYTE_REQ,
  output logic [7:0] LINK_RDATA,
  output logic LINK_RDATA_VALID,
  input wire logic [7:0] FAULT_IN,
  input wire logic [7:0] ALERT_MASK,
  input wire logic OUTPUT_REENABLE,
  input wire logic SYS_EVENT_VALID,
  input wire logic [7:0] SYS_CODE,
  input wire logic ONOFF_EVENT_VALID,
  input wire logic [3:0] ONOFF_SOURCE,
  input wire logic ONOFF_TURNED_ON,
  input wire logic POWER_OK,
  input wire logic [55:0] STATUS_BYTES,
  input wire logic [63:0] TELEMETRY,
  output logic FAULT_ALERT_LINE_N,
  output logic BUSY
);
  //------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------
  logic [7:0] flt_s1_q, flt_s2_q, flt_prev_q;
  logic pok_s1_q, pok_s2_q, pok_prev_q, reen_s1_q, reen_s2_q;
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      flt_s1_q <= 8'h00;
      flt_s2_q <= 8'h00;
      flt_prev_q <= 8'h00;
      pok_s1_q <= 1'b0;
      pok_s2_q <= 1'b0;
      pok_prev_q <= 1'b0;
      reen_s1_q <= 1'b0;
      reen_s2_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      flt_s1_q <= FAULT_IN;
      flt_s2_q <= flt_s1_q;
      flt_prev_q <= flt_s2_q;
      pok_s1_q <= POWER_OK;
      pok_s2_q <= pok_s1_q;
      pok_prev_q <= pok_s2_q;
      reen_s1_q <= OUTPUT_REENABLE;
      reen_s2_q <= reen_s1_q;
    end
  //------------------------------------------------------------
  // Link side: command capture and read-back on LINK_CLK
  //------------------------------------------------------------
  logic lk_req_tgl_q, lk_wr_q;
  logic [7:0] lk_cmd_q, lk_wdata_q;
  logic [7:0] lk_byte_idx_q;
  logic [7:0] selector_q, status_q;
  logic [183:0] blk_q;
  logic [183:0] blk_s1_q, blk_s2_q;
  logic [7:0] sel_s1_q, sel_s2_q, stat_s1_q, stat_s2_q;
  always_ff @(posedge LINK_CLK or negedge RESETN)
    if (!RESETN)
    begin
      lk_req_tgl_q <= 1'b0;
      lk_wr_q <= 1'b0;
      lk_cmd_q <= 8'h00;
      lk_wdata_q <= 8'h00;
    end
    else if (LINK_CMD_VALID)
    begin
      lk_req_tgl_q <= ~lk_req_tgl_q;
      lk_wr_q <= LINK_WR;
      lk_cmd_q <= LINK_CMD;
      lk_wdata_q <= LINK_WDATA;
    end
  // Snapshot words are held stable by core between commands, so bus-wide sync is safe
  always_ff @(posedge LINK_CLK or negedge RESETN)
    if (!RESETN)
    begin
      blk_s1_q <= '1;
      blk_s2_q <= '1;
      sel_s1_q <= 8'h00;
      sel_s2_q <= 8'h00;
      stat_s1_q <= 8'h00;
      stat_s2_q <= 8'h00;
    end
    else
    begin
      blk_s1_q <= blk_q;
      blk_s2_q <= blk_s1_q;
      sel_s1_q <= selector_q;
      sel_s2_q <= sel_s1_q;
      stat_s1_q <= status_q;
      stat_s2_q <= stat_s1_q;
    end
  always_ff @(posedge LINK_CLK or negedge RESETN)
    if (!RESETN)
    begin
      lk_byte_idx_q <= 8'h00;
      LINK_RDATA <= 8'h00;
      LINK_RDATA_VALID <= 1'b0;
    end
    else
    begin
      LINK_RDATA_VALID <= LINK_BYTE_REQ;
      if (LINK_CMD_VALID)
        lk_byte_idx_q <= 8'h00;
      else if (LINK_BYTE_REQ)
      begin
        lk_byte_idx_q <= lk_byte_idx_q + 8'h01;
        unique case (lk_cmd_q)
          `PFER_CMD_SELECTOR: LINK_RDATA <= sel_s2_q;
          `PFER_CMD_STATUS_BYTE: LINK_RDATA <= stat_s2_q;
          `PFER_CMD_READ_EVENT:
            if (lk_byte_idx_q == 8'h00)
              LINK_RDATA <= `PFER_BLOCK_LEN;
            else if (lk_byte_idx_q <= `PFER_BLOCK_LEN)
              LINK_RDATA <= blk_s2_q[8'd184 - 8'd8 * lk_byte_idx_q +: 8];
            else
              LINK_RDATA <= `PFER_EMPTY_BYTE;
          default: LINK_RDATA <= `PFER_EMPTY_BYTE;
        endcase
      end
    end
  //------------------------------------------------------------
  // Command crossing into core domain
  //------------------------------------------------------------
  logic req_s1_q, req_s2_q, req_s3_q, cmd_evt;
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      req_s1_q <= lk_req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  assign cmd_evt = CLK_EN && (req_s2_q != req_s3_q);
  wire logic do_sel = cmd_evt && lk_wr_q && lk_cmd_q == `PFER_CMD_SELECTOR;
  wire logic do_clr = cmd_evt && lk_wr_q && lk_cmd_q == `PFER_CMD_CLEAR_FAULTS;
  //------------------------------------------------------------
  // Timebase and idle timeout
  //------------------------------------------------------------
  logic [31:0] tick_cnt_q, stamp_q, idle_q;
  logic tick;
  assign tick = tick_cnt_q == TICK_CYCLES - 1;
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      tick_cnt_q <= 32'h0;
      stamp_q <= 32'h0;
    end
    else if (CLK_EN)
    begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      if (tick)
        stamp_q <= stamp_q + 32'h1;
    end
  //------------------------------------------------------------
  // Event sourcing
  //------------------------------------------------------------
  pfer_pkg::pfer_state_t st_q;
  logic [7:0] rise;
  logic log_fault, log_life, sys_fault_ok, timeout;
  logic [15:0] ev_word;
  logic [7:0] ev_mfr;
  logic wipe_pend_q, clr_pend_q;
  assign rise = flt_s2_q & ~flt_prev_q;
  assign timeout = idle_q >= IDLE_TICKS;
  assign sys_fault_ok = SYS_CODE == `PFER_SYS_INPUT_LOW || SYS_CODE == `PFER_SYS_CANCEL
    || SYS_CODE == `PFER_SYS_WIPE_OVERFLOW;
  always_comb
  begin
    ev_word = 16'h0;
    ev_mfr = 8'h00;
    log_fault = 1'b0;
    log_life = 1'b0;
    if (st_q != pfer_pkg::PFER_IDLE)
    begin
      log_fault = 1'b0;
    end
    else if (wipe_pend_q)
    begin
      ev_word = `PFER_SW_SYSTEM;
      ev_mfr = `PFER_SYS_ERASE;
      log_life = 1'b1;
    end
    else if (clr_pend_q)
    begin
      ev_word = `PFER_SW_SYSTEM;
      ev_mfr = `PFER_SYS_FAULT_CLEAR;
      log_life = 1'b1;
    end
    else if (|(rise & ~ALERT_MASK))
    begin
      ev_word = {8'h00, flt_s2_q};
      log_fault = 1'b1;
    end
    else if (timeout)
    begin
      ev_word = `PFER_SW_SYSTEM;
      ev_mfr = `PFER_SYS_CANCEL;
      log_life = 1'b1;
      log_fault = 1'b1;
    end
    else if (SYS_EVENT_VALID)
    begin
      ev_word = `PFER_SW_SYSTEM;
      ev_mfr = SYS_CODE;
      log_life = 1'b1;
      log_fault = sys_fault_ok;
    end
    else if (ONOFF_EVENT_VALID)
    begin
      ev_word = `PFER_SW_UNIT_OFF;
      ev_mfr = {3'b000, ONOFF_TURNED_ON, ONOFF_SOURCE};
      log_life = 1'b1;
    end
    else if (pok_s2_q != pok_prev_q)
    begin
      ev_word = `PFER_SW_POWER_OK;
      ev_mfr = pok_s2_q ? `PFER_PG_HIGH_CODE : `PFER_PG_LOW_CODE;
      log_life = 1'b1;
    end
  end
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      idle_q <= 32'h0;
    else if (CLK_EN)
    begin
      if (log_fault || log_life)
        idle_q <= 32'h0;
      else if (tick)
        idle_q <= idle_q + 32'h1;
    end
  //------------------------------------------------------------
  // Event storage: two circular banks
  //------------------------------------------------------------
  pfer_pkg::pfer_event_t mem_q [2*SLOTS];
  logic [4:0] head_q [2], count_q [2];
  logic [15:0] serial_q [2];
  logic [31:0] wipe_cnt_q;
  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : g_bank
      wire logic wr = (b == 0) ? log_fault : log_life;
      wire logic wipe_b = (b == 0) && st_q == pfer_pkg::PFER_WIPE && wipe_cnt_q == 32'h0;
      wire logic full = count_q[b] == 5'(SLOTS);
      always_ff @(posedge CLK or negedge RESETN)
        if (!RESETN)
        begin
          head_q[b] <= 5'h0;
          count_q[b] <= 5'h0;
          serial_q[b] <= 16'h0;
        end
        else if (CLK_EN)
        begin
          if (wipe_b)
          begin
            count_q[b] <= 5'h0;
            serial_q[b] <= 16'h0;
          end
          else if (wr)
          begin
            serial_q[b] <= serial_q[b] + 16'h1;
            if (full)
            begin
              head_q[b] <= 5'((head_q[b] + `PFER_DROP_COUNT) % SLOTS);
              count_q[b] <= 5'(SLOTS - `PFER_DROP_COUNT + 1);
            end
            else
              count_q[b] <= count_q[b] + 5'h1;
          end
        end
      wire logic [4:0] wslot = 5'((head_q[b] + count_q[b]) % SLOTS);
      always_ff @(posedge CLK)
        if (CLK_EN && wr && !wipe_b)
          mem_q[b*SLOTS + wslot] <= '{serial_q[b], stamp_q, ev_word,
            {STATUS_BYTES[55:8], ev_mfr}, TELEMETRY};
    end
  endgenerate
  //------------------------------------------------------------
  // Selector, wipe sequence and read snapshot
  //------------------------------------------------------------
  logic [5:0] look_q;
  logic alert_q;
  // Empty bank gives an index past the last slot, so every byte after the length byte reads 0xff
  wire logic [7:0] newest_life = (count_q[1] == 5'h0) ? `PFER_EMPTY_BYTE
    : `PFER_LIFE_BASE + 8'(count_q[1]) - 8'h01;
  wire logic [7:0] newest_fault = 8'(count_q[0]) - 8'h01;
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      st_q <= pfer_pkg::PFER_IDLE;
      selector_q <= 8'h00;
      look_q <= 6'h0;
      wipe_pend_q <= 1'b0;
      clr_pend_q <= 1'b0;
      wipe_cnt_q <= 32'h0;
    end
    else if (CLK_EN)
    begin
      if (do_clr)
        clr_pend_q <= 1'b1;
      else if (clr_pend_q && !wipe_pend_q && st_q == pfer_pkg::PFER_IDLE)
        clr_pend_q <= 1'b0;
      if (st_q == pfer_pkg::PFER_IDLE && wipe_pend_q)
        wipe_pend_q <= 1'b0;
      unique case (st_q)
        pfer_pkg::PFER_IDLE:
          if (do_sel)
          begin
            selector_q <= lk_wdata_q;
            st_q <= pfer_pkg::PFER_LOG;
            if (lk_wdata_q == `PFER_SEL_WIPE)
            begin
              st_q <= pfer_pkg::PFER_WIPE;
              wipe_cnt_q <= WIPE_CYCLES - 1;
            end
            else if (lk_wdata_q == `PFER_SEL_NEWEST_LIFE)
            begin
              selector_q <= newest_life;
              look_q <= newest_life[5:0];
            end
            else if (lk_wdata_q == `PFER_SEL_NEWEST_FAULT)
            begin
              selector_q <= newest_fault;
              look_q <= newest_fault[5:0];
            end
            else
              look_q <= lk_wdata_q[5:0];
          end
        pfer_pkg::PFER_LOG:
          st_q <= pfer_pkg::PFER_IDLE;
        pfer_pkg::PFER_WIPE:
          if (wipe_cnt_q == 32'h0)
          begin
            st_q <= pfer_pkg::PFER_IDLE;
            wipe_pend_q <= 1'b1;
          end
          else
            wipe_cnt_q <= wipe_cnt_q - 32'h1;
        default: st_q <= pfer_pkg::PFER_IDLE;
      endcase
    end
  // Snapshot update taken in the LOG state
  wire logic in_life = look_q >= 6'(`PFER_LIFE_BASE);
  wire logic [4:0] rel = in_life ? 5'(look_q - 6'(`PFER_LIFE_BASE)) : look_q[4:0];
  wire logic [4:0] bk_cnt = in_life ? count_q[1] : count_q[0];
  wire logic [4:0] bk_head = in_life ? head_q[1] : head_q[0];
  wire logic [5:0] phys = 6'(in_life ? SLOTS : 0) + 6'((bk_head + rel) % SLOTS);
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      blk_q <= '1;
    else if (CLK_EN && st_q == pfer_pkg::PFER_LOG)
    begin
      if (look_q > 6'(`PFER_LAST_INDEX) || rel >= bk_cnt)
        blk_q <= '1;
      else
        blk_q <= mem_q[phys];
    end
  //------------------------------------------------------------
  // Alert line and busy status
  //------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      alert_q <= 1'b0;
      FAULT_ALERT_LINE_N <= 1'b1;
      BUSY <= 1'b0;
      status_q <= 8'h00;
    end
    else if (CLK_EN)
    begin
      // Fault handling paused while wiping; an unmasked fault still present wins over a clear
      if (st_q != pfer_pkg::PFER_WIPE && |(flt_s2_q & ~ALERT_MASK))
        alert_q <= 1'b1;
      else if (do_clr || reen_s2_q)
        alert_q <= 1'b0;
      FAULT_ALERT_LINE_N <= ~alert_q;
      BUSY <= st_q != pfer_pkg::PFER_IDLE;
      status_q <= {st_q != pfer_pkg::PFER_IDLE, 7'h00};
    end
endmodule
`default_nettype wire

// >>> pfer_regs.svh
// Register offsets, codes and timing constants of the fault event recorder
`ifndef PFER_REGS_SVH
`define PFER_REGS_SVH
`define PFER_CMD_SELECTOR 8'hdb
`define PFER_CMD_READ_EVENT 8'hd7
`define PFER_CMD_CLEAR_FAULTS 8'h03
`define PFER_CMD_STATUS_BYTE 8'h78
`define PFER_BLOCK_LEN 8'h17
`define PFER_BANK_SLOTS 24
`define PFER_LIFE_BASE 8'h18
`define PFER_LAST_INDEX 8'h2f
`define PFER_SEL_NEWEST_LIFE 8'hfe
`define PFER_SEL_NEWEST_FAULT 8'hff
`define PFER_SEL_WIPE 8'haa
`define PFER_DROP_COUNT 4
`define PFER_EMPTY_BYTE 8'hff
`define PFER_SW_SYSTEM 16'h0001
`define PFER_SW_UNIT_OFF 16'h0040
`define PFER_SW_POWER_OK 16'h0800
`define PFER_SYS_BOOT 8'h01
`define PFER_SYS_INPUT_LOW 8'h02
`define PFER_SYS_CANCEL 8'h04
`define PFER_SYS_ERASE 8'h08
`define PFER_SYS_FAULT_CLEAR 8'h10
`define PFER_SYS_WIPE_OVERFLOW 8'h20
`define PFER_PG_LOW_CODE 8'h01
`define PFER_PG_HIGH_CODE 8'h02
`define PFER_ONOFF_DIR_BIT 4
`define PFER_BUSY_BIT 7
`define PFER_DEFAULT_MASK 8'h00
`define PFER_TICK_MS 100
`define PFER_CLK_MHZ 125
`define PFER_WIPE_MS 121
`define PFER_PREP_US 30
`define PFER_IDLE_TICKS 32'd662709600
`endif

// >>> pfer_pkg.sv
// Types shared by the fault event recorder
package pfer_pkg;
  typedef enum logic [1:0] {
    PFER_IDLE = 2'b00,
    PFER_LOG = 2'b01,
    PFER_WIPE = 2'b10
  } pfer_state_t;
  typedef struct packed {
    logic [15:0] serial;
    logic [31:0] stamp;
    logic [15:0] word;
    logic [55:0] stat;
    logic [63:0] tele;
  } pfer_event_t;
endpackage

// >>> pfer_recorder_chk.sv
// Port assertions for the fault event recorder
`timescale 1ns/100ps
`default_nettype none
// ----
// Checker
// ----
module pfer_recorder_chk #(
  parameter int unsigned WIPE_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic LINK_BYTE_REQ,
  input wire logic [7:0] LINK_RDATA,
  input wire logic LINK_RDATA_VALID,
  input wire logic [7:0] FAULT_IN,
  input wire logic [7:0] ALERT_MASK,
  input wire logic OUTPUT_REENABLE,
  input wire logic FAULT_ALERT_LINE_N,
  input wire logic BUSY
);
  logic act;
  logic [15:0] busy_len_q;
  assign act = (FAULT_IN & ~ALERT_MASK) != 8'h00;
  // Short busy spells are the one-cycle LOG state after a selector write, long ones a wipe
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      busy_len_q <= 16'h0000;
    else if (BUSY)
      busy_len_q <= busy_len_q + 16'h0001;
    else
      busy_len_q <= 16'h0000;
  property p_byte_answer;
    @(posedge LINK_CLK) disable iff (!RESETN) LINK_BYTE_REQ |=> LINK_RDATA_VALID;
  endproperty
  a_byte_answer: assert property (p_byte_answer) else $error("read byte not answered");
  property p_answer_cause;
    @(posedge LINK_CLK) disable iff (!RESETN) LINK_RDATA_VALID |-> $past(LINK_BYTE_REQ);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("read byte without request");
  property p_rdata_stands;
    @(posedge LINK_CLK) disable iff (!RESETN) !$past(LINK_BYTE_REQ) |-> $stable(LINK_RDATA);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read byte moved unasked");
  property p_alert_on_fault;
    @(posedge CLK) disable iff (!RESETN)
      $rose(act) && !BUSY && !OUTPUT_REENABLE |-> ##[1:8] !FAULT_ALERT_LINE_N;
  endproperty
  a_alert_on_fault: assert property (p_alert_on_fault) else $error("alert missing");
  property p_alert_cause;
    // Two sync stages, alert flop and output flop lie between pin and line
    @(posedge CLK) disable iff (!RESETN) $fell(FAULT_ALERT_LINE_N) |-> $past(act, 4);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without unmasked fault");
  property p_alert_quiet;
    @(posedge CLK) disable iff (!RESETN) (FAULT_ALERT_LINE_N && !act) [*6] |=> FAULT_ALERT_LINE_N;
  endproperty
  a_alert_quiet: assert property (p_alert_quiet) else $error("alert from masked source");
  property p_reenable_clears;
    @(posedge CLK) disable iff (!RESETN) (OUTPUT_REENABLE && !act) [*6] |-> FAULT_ALERT_LINE_N;
  endproperty
  a_reenable_clears: assert property (p_reenable_clears) else $error("alert kept after re-enable");
  property p_wipe_busy;
    @(posedge CLK) disable iff (!RESETN) $fell(BUSY) |->
      busy_len_q <= WIPE_CYCLES + 4 && (busy_len_q < 4 || busy_len_q >= WIPE_CYCLES);
  endproperty
  a_wipe_busy: assert property (p_wipe_busy) else $error("busy spell of wrong length");
endmodule
`default_nettype wire

// >>> pfer_host_model.sv
// Host-side link model for the fault event recorder
`include "pfer_regs.svh"
`timescale 1ns/100ps
`default_nettype none
// ----
// Host model
// ----
module pfer_host_model #(
  // Shortened wait; the design needs only 4 CLK and 3 link edges
  parameter int PREP_NS = 500
) (
  input wire logic LINK_CLK,
  output logic LINK_CMD_VALID,
  output logic [7:0] LINK_CMD,
  output logic LINK_WR,
  output logic [7:0] LINK_WDATA,
  output logic LINK_BYTE_REQ,
  input wire logic [7:0] LINK_RDATA,
  input wire logic LINK_RDATA_VALID
);
  initial
  begin
    LINK_CMD_VALID = 1'b0;
    LINK_CMD = 8'h00;
    LINK_WR = 1'b0;
    LINK_WDATA = 8'h00;
    LINK_BYTE_REQ = 1'b0;
  end
  // Never sends a memory store, so the extra wait after one is never owed
  task automatic cmd(input logic [7:0] c, input logic w, input logic [7:0] d);
    repeat (4) @(posedge LINK_CLK);
    #1;
    LINK_CMD_VALID = 1'b1;
    LINK_CMD = c;
    LINK_WR = w;
    LINK_WDATA = d;
    @(posedge LINK_CLK);
    #1;
    // Released lines never keep the old value
    LINK_CMD_VALID = 1'b0;
    LINK_CMD = ~c;
    LINK_WR = ~w;
    LINK_WDATA = ~d;
  endtask
  task automatic sel(input logic [7:0] idx);
    cmd(`PFER_CMD_SELECTOR, 1'b1, idx);
    #(PREP_NS);
  endtask
  task automatic rd(output logic [7:0] v, output logic ok);
    int k;
    @(posedge LINK_CLK);
    #1;
    LINK_BYTE_REQ = 1'b1;
    @(posedge LINK_CLK);
    #1;
    LINK_BYTE_REQ = 1'b0;
    ok = 1'b0;
    v = 8'h00;
    for (k = 0; k < 4 && !ok; k++)
      if (LINK_RDATA_VALID === 1'b1)
      begin
        ok = 1'b1;
        v = LINK_RDATA;
      end
      else
        @(posedge LINK_CLK) #1;
  endtask
endmodule
`default_nettype wire

// >>> pfer_recorder_test.sv
// Self-checking bench for the fault event recorder
`include "pfer_regs.svh"
`timescale 1ns/100ps
`default_nettype none
// ----
// Bench
// ----
module pfer_recorder_test;
  localparam int TICK = 10;
  localparam int WIPE = 20;
  localparam int IDLE = 600;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid, wr, byte_req, rdata_valid, alert_n, busy;
  logic [7:0] cmd, wdata, rdata, b;
  logic [7:0] fault_in = 8'h00;
  logic [7:0] alert_mask = 8'h00;
  logic reenable = 1'b0;
  logic sys_valid = 1'b0;
  logic [7:0] sys_code = 8'h00;
  logic onoff_valid = 1'b0;
  logic [3:0] onoff_src = 4'h0;
  logic onoff_on = 1'b0;
  logic power_ok = 1'b0;
  logic [55:0] stat_bytes = 56'h11223344556677;
  logic [63:0] tele = 64'h0102a3b4c5d6e7f8;
  logic [7:0] ev [0:23];
  logic [15:0] s0;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  // Rising edges never meet: 4+8k is even, 15+30m is odd
  always #4 clk = ~clk;
  always #15 link_clk = ~link_clk;
  pfer_recorder #(.TICK_CYCLES(TICK), .WIPE_CYCLES(WIPE), .IDLE_TICKS(32'(IDLE))) u_pfer_recorder (
    .CLK(clk), .RESETN(resetn), .CLK_EN(1'b1), .LINK_CLK(link_clk),
    .LINK_CMD_VALID(cmd_valid), .LINK_CMD(cmd), .LINK_WR(wr), .LINK_WDATA(wdata),
    .LINK_BYTE_REQ(byte_req), .LINK_RDATA(rdata), .LINK_RDATA_VALID(rdata_valid),
    .FAULT_IN(fault_in), .ALERT_MASK(alert_mask), .OUTPUT_REENABLE(reenable),
    .SYS_EVENT_VALID(sys_valid), .SYS_CODE(sys_code), .ONOFF_EVENT_VALID(onoff_valid),
    .ONOFF_SOURCE(onoff_src), .ONOFF_TURNED_ON(onoff_on), .POWER_OK(power_ok),
    .STATUS_BYTES(stat_bytes), .TELEMETRY(tele), .FAULT_ALERT_LINE_N(alert_n), .BUSY(busy));
  pfer_host_model u_pfer_host_model (
    .LINK_CLK(link_clk), .LINK_CMD_VALID(cmd_valid), .LINK_CMD(cmd), .LINK_WR(wr),
    .LINK_WDATA(wdata), .LINK_BYTE_REQ(byte_req), .LINK_RDATA(rdata), .LINK_RDATA_VALID(rdata_valid));
  task automatic print_verdict();
    $display("compared %0d values, %0d wrong", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_test(input string s);
    $display("test %s finished, %0d wrong so far", s, error_cnt);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic get(output logic [7:0] v);
    logic ok;
    u_pfer_host_model.rd(v, ok);
    if (!ok)
    begin
      error_cnt++;
      $display("wrong value at %0t: read byte never came", $time);
      print_verdict();
    end
  endtask
  task automatic rd_reg(input logic [7:0] c, output logic [7:0] v);
    u_pfer_host_model.cmd(c, 1'b0, 8'h00);
    get(v);
  endtask
  task automatic rd_ev(input logic [7:0] idx);
    int k;
    u_pfer_host_model.sel(idx);
    u_pfer_host_model.cmd(`PFER_CMD_READ_EVENT, 1'b0, 8'h00);
    for (k = 0; k < 24; k++)
      get(ev[k]);
  endtask
  task automatic chk_ev(input logic [7:0] idx, input logic [15:0] w, input logic [7:0] m);
    rd_ev(idx);
    check(ev[0], `PFER_BLOCK_LEN);
    check({ev[7], ev[8]}, w);
    check(ev[15], m);
  endtask
  task automatic wait_alert(input logic e);
    int k;
    for (k = 0; k < 30 && alert_n !== e; k++)
      cyc(1);
    check(alert_n, e);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    check(alert_n, 1'b1);
    check(busy, 1'b0);
    cyc(2);
    sys_code = `PFER_SYS_BOOT;
    sys_valid = 1'b1;
    cyc(1);
    sys_valid = 1'b0;
    chk_ev(`PFER_LIFE_BASE, `PFER_SW_SYSTEM, `PFER_SYS_BOOT);
    onoff_src = 4'h2;
    onoff_on = 1'b1;
    onoff_valid = 1'b1;
    cyc(1);
    onoff_valid = 1'b0;
    chk_ev(`PFER_SEL_NEWEST_LIFE, `PFER_SW_UNIT_OFF, 8'h12);
    power_ok = 1'b1;
    chk_ev(`PFER_SEL_NEWEST_LIFE, `PFER_SW_POWER_OK, `PFER_PG_HIGH_CODE);
    power_ok = 1'b0;
    chk_ev(`PFER_SEL_NEWEST_LIFE, `PFER_SW_POWER_OK, `PFER_PG_LOW_CODE);
    end_test("life");
    fault_in = 8'h04;
    wait_alert(1'b0);
    fault_in = 8'h00;
    cyc(10);
    check(alert_n, 1'b0);
    rd_ev(8'h00);
    s0 = {ev[1], ev[2]};
    check({ev[7], ev[8]}, 16'h0004);
    for (n = 0; n < 6; n++)
      check(ev[9 + n], stat_bytes[55 - 8 * n -: 8]);
    for (n = 0; n < 8; n++)
      check(ev[16 + n], tele[63 - 8 * n -: 8]);
    // Clear goes out as a write with no meaningful data byte
    u_pfer_host_model.cmd(`PFER_CMD_CLEAR_FAULTS, 1'b1, 8'h00);
    wait_alert(1'b1);
    chk_ev(`PFER_SEL_NEWEST_LIFE, `PFER_SW_SYSTEM, `PFER_SYS_FAULT_CLEAR);
    alert_mask = 8'h08;
    fault_in = 8'h08;
    cyc(20);
    check(alert_n, 1'b1);
    fault_in = 8'h00;
    cyc(10);
    fault_in = 8'h01;
    wait_alert(1'b0);
    fault_in = 8'h00;
    reenable = 1'b1;
    wait_alert(1'b1);
    // Held on so the re-enable assertion sees six quiet cycles
    cyc(4);
    reenable = 1'b0;
    rd_ev(`PFER_SEL_NEWEST_FAULT);
    check({ev[1], ev[2]}, s0 + 16'h0001);
    rd_reg(`PFER_CMD_SELECTOR, b);
    check(b, 8'h01);
    rd_ev(`PFER_LAST_INDEX);
    for (n = 1; n < 24; n++)
      check(ev[n], `PFER_EMPTY_BYTE);
    rd_reg(`PFER_CMD_SELECTOR, b);
    check(b, `PFER_LAST_INDEX);
    end_test("fault");
    u_pfer_host_model.cmd(`PFER_CMD_SELECTOR, 1'b1, `PFER_SEL_WIPE);
    for (n = 0; n < 20 && busy !== 1'b1; n++)
      cyc(1);
    check(busy, 1'b1);
    // Host keeps off the link until the wipe is over
    for (n = 0; n < 4 * WIPE && busy !== 1'b0; n++)
      cyc(1);
    check(busy, 1'b0);
    rd_reg(`PFER_CMD_SELECTOR, b);
    check(b, `PFER_SEL_WIPE);
    rd_reg(`PFER_CMD_STATUS_BYTE, b);
    check(b, 8'h00);
    rd_ev(8'h00);
    check(ev[5], `PFER_EMPTY_BYTE);
    chk_ev(`PFER_SEL_NEWEST_LIFE, `PFER_SW_SYSTEM, `PFER_SYS_ERASE);
    end_test("wipe");
    for (n = 0; n < 25; n++)
    begin
      fault_in = 8'h02;
      cyc(8);
      fault_in = 8'h00;
      cyc(8);
    end
    u_pfer_host_model.sel(`PFER_SEL_NEWEST_FAULT);
    rd_reg(`PFER_CMD_SELECTOR, b);
    check(b, 8'h14);
    rd_ev(8'h00);
    check({ev[1], ev[2]}, s0 + 16'h0004);
    end_test("fill");
    cyc(IDLE * TICK + 200);
    chk_ev(`PFER_SEL_NEWEST_LIFE, `PFER_SW_SYSTEM, `PFER_SYS_CANCEL);
    chk_ev(`PFER_SEL_NEWEST_FAULT, `PFER_SW_SYSTEM, `PFER_SYS_CANCEL);
    end_test("idle");
    print_verdict();
  end
endmodule
bind pfer_recorder pfer_recorder_chk #(.WIPE_CYCLES(WIPE_CYCLES)) u_pfer_recorder_chk (
  .CLK(CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK), .LINK_BYTE_REQ(LINK_BYTE_REQ),
  .LINK_RDATA(LINK_RDATA), .LINK_RDATA_VALID(LINK_RDATA_VALID), .FAULT_IN(FAULT_IN),
  .ALERT_MASK(ALERT_MASK), .OUTPUT_REENABLE(OUTPUT_REENABLE),
  .FAULT_ALERT_LINE_N(FAULT_ALERT_LINE_N), .BUSY(BUSY));
`default_nettype wire
